/* verilog/bridge_command_error_irq_ctl.sv */
/*
 * upper command-register controls of a switch bridge: poisoned TLP logging,
 * error reporting and forwarding, own INTx masking, plus the two status flags.
 * assumes config access as one-cycle rd/wr strobes on clk_sys_i, same domain.
 */
`timescale 1ns/1ps
`include "cmd_err_regs.svh"
module bridge_command_error_irq_ctl
   import cmd_err_pkg::*;
(
   input  wire logic        clk_sys_i,        // 40 MHz system clock
   input  wire logic        rst_i,            // sync reset, active high
   input  wire logic        ce_i,             // clock enable
   input  wire cfg_req_type cfg_i,            // config read/write request
   output      logic [15:0] cfg_rdata_o,      // config read data
   output      logic        cfg_rvalid_o,     // read data valid
   input  wire logic        poison_cpl_dn_i,  // poisoned completion downstream
   input  wire logic        poison_req_up_i,  // poisoned request upstream
   input  wire logic        det_nonfatal_i,   // bridge detected nonfatal
   input  wire logic        det_fatal_i,      // bridge detected fatal
   input  wire logic        dev_nonfatal_en_i,// device control nonfatal enable
   input  wire logic        dev_fatal_en_i,   // device control fatal enable
   input  wire err_msg_type sec_msg_i,        // secondary error messages
   input  wire logic [3:0]  sec_intx_i,       // secondary INTx levels
   input  wire logic        own_intx_i,       // bridge's own interrupt request
   output      err_msg_type pri_msg_o,        // forwarded messages to primary
   output      err_msg_type own_msg_o,        // bridge's own error messages
   output      logic [3:0]  pri_intx_o,       // forwarded INTx to primary
   output      logic        own_intx_o,       // resolved own INTx
   output      logic        perr_en_o,        // parity response enable
   output      logic        serr_en_o,        // error report enable
   output      logic        irq_dis_o         // interrupt disable
);
   logic [15:0] cmd_r, cmd_nxt;
   logic [15:0] sts_r, sts_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic        rvalid_r, rvalid_nxt;
   err_msg_type own_r, own_nxt;
   logic        intx_r, intx_nxt;
   logic        perr_en, serr_en, irq_dis;
   logic        mdpe_set, sse_set;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   assign perr_en = cmd_r[`CMD_PERR_BIT];
   assign serr_en = cmd_r[`CMD_SERR_BIT];
   assign irq_dis = cmd_r[`CMD_IRQDIS_BIT];

   always_comb begin
      own_nxt.corr     = 1'b0;
      own_nxt.nonfatal = det_nonfatal_i & (serr_en | dev_nonfatal_en_i);
      own_nxt.fatal    = det_fatal_i & (serr_en | dev_fatal_en_i);
      // masked ahead of the register: the resolved state drops one cycle after the write
      intx_nxt         = own_intx_i & ~irq_dis;
   end

   // status flag sources; set beats a same-cycle write-one clear
   assign mdpe_set = perr_en & (poison_cpl_dn_i | poison_req_up_i);
   assign sse_set  = serr_en & (own_nxt.nonfatal | own_nxt.fatal);

   always_comb begin
      cmd_nxt    = cmd_r;
      sts_nxt    = sts_r;
      rdata_nxt  = rdata_r;
      rvalid_nxt = 1'b0;
      if (cfg_i.wr && hit(cfg_i.addr, `CMD_OFFSET)) begin
         // only three control bits take writes
         cmd_nxt = cfg_i.wdata & `CMD_RW_MASK;
      end
      if (cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET)) begin
         if (cfg_i.wdata[`STS_MDPE_BIT]) sts_nxt[`STS_MDPE_BIT] = 1'b0;
         if (cfg_i.wdata[`STS_SSE_BIT])  sts_nxt[`STS_SSE_BIT]  = 1'b0;
      end
      if (mdpe_set) sts_nxt[`STS_MDPE_BIT] = 1'b1;
      if (sse_set)  sts_nxt[`STS_SSE_BIT]  = 1'b1;
      // read data is held between reads; only rvalid marks a fresh word
      if (cfg_i.rd) begin
         rvalid_nxt = 1'b1;
         if (hit(cfg_i.addr, `CMD_OFFSET))      rdata_nxt = cmd_r & `CMD_RW_MASK;
         else if (hit(cfg_i.addr, `STS_OFFSET)) rdata_nxt = sts_r;
         else                                   rdata_nxt = 16'h0000;
      end
   end

   // reset ignores the clock enable so a frozen block still comes up clean
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmd_r    <= `CMD_RESET;
         sts_r    <= `STS_RESET;
         rdata_r  <= 16'h0000;
         rvalid_r <= 1'b0;
         own_r    <= '0;
         intx_r   <= 1'b0;
      end else if (ce_i) begin
         cmd_r    <= cmd_nxt;
         sts_r    <= sts_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
         own_r    <= own_nxt;
         intx_r   <= intx_nxt;
      end
   end

   // forwarded traffic gets the same one-cycle stage as the bridge's own messages
   msg_fwd u_fwd (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .serr_en_i  (serr_en),
      .sec_msg_i  (sec_msg_i),
      .sec_intx_i (sec_intx_i),
      .pri_msg_o  (pri_msg_o),
      .pri_intx_o (pri_intx_o)
   );

   assign cfg_rdata_o  = rdata_r;
   assign cfg_rvalid_o = rvalid_r;
   assign own_msg_o    = own_r;
   assign own_intx_o   = intx_r;
   assign perr_en_o    = perr_en;
   assign serr_en_o    = serr_en;
   assign irq_dis_o    = irq_dis;

   // checks
   mdpe_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !perr_en && !$past(sts_r[`STS_MDPE_BIT]) && !sts_r[`STS_MDPE_BIT]
      |=> !sts_r[`STS_MDPE_BIT]) else $error("parity flag set while disabled");
   mdpe_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && mdpe_set |=> sts_r[`STS_MDPE_BIT]) else $error("parity flag missed");
   err_report_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && det_fatal_i && serr_en |=> own_msg_o.fatal) else $error("fatal not reported");
   fwd_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sec_msg_i.fatal && !serr_en |=> !pri_msg_o.fatal)
      else $error("fatal forwarded while disabled");
   corr_fwd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sec_msg_i.corr |=> pri_msg_o.corr) else $error("correctable dropped");
   intx_mask_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && irq_dis |=> !own_intx_o) else $error("own INTx not negated");
   intx_pass_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i |=> pri_intx_o == $past(sec_intx_i)) else $error("forwarded INTx altered");
   ro_bits_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cmd_r[`CMD_PALETTE_BIT] == 1'b0 && cmd_r[`CMD_STEP_BIT] == 1'b0
      && cmd_r[`CMD_FAST_BACK_TO_BACK_EN_BIT] == 1'b0) else $error("read-only bit set");
   reset_val_a: assert property (@(posedge clk_sys_i)
      rst_i |=> cmd_r == 16'h0000) else $error("command not cleared");
   sse_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && serr_en && det_nonfatal_i |=> sts_r[`STS_SSE_BIT])
      else $error("system error flag missed");
   rsvd_read_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cfg_rvalid_o |-> cfg_rdata_o[15:11] == 5'h00 || $past(cfg_i.addr) != `CMD_OFFSET)
      else $error("reserved bits read nonzero");

   // own reports, own INTx and forwarding
   nf_report_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && det_nonfatal_i && dev_nonfatal_en_i |=> own_msg_o.nonfatal)
      else $error("nonfatal not reported");
   no_report_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && det_fatal_i && !serr_en && !dev_fatal_en_i |=> !own_msg_o.fatal)
      else $error("fatal reported while disabled");
   nf_fwd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sec_msg_i.nonfatal && serr_en |=> pri_msg_o.nonfatal)
      else $error("nonfatal not forwarded");
   nf_gate_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sec_msg_i.nonfatal && !serr_en |=> !pri_msg_o.nonfatal)
      else $error("nonfatal forwarded while disabled");
   fatal_fwd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sec_msg_i.fatal && serr_en |=> pri_msg_o.fatal)
      else $error("fatal not forwarded");
   intx_own_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !irq_dis |=> own_intx_o == $past(own_intx_i))
      else $error("own INTx lost while enabled");

   // register access
   cmd_write_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && cfg_i.wr && hit(cfg_i.addr, `CMD_OFFSET)
      |=> irq_dis_o == $past(cfg_i.wdata[`CMD_IRQDIS_BIT])
      && serr_en_o == $past(cfg_i.wdata[`CMD_SERR_BIT])
      && perr_en_o == $past(cfg_i.wdata[`CMD_PERR_BIT]))
      else $error("control write lost");
   rvalid_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && cfg_i.rd |=> cfg_rvalid_o)
      else $error("read not answered");
   unmapped_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && cfg_i.rd && !hit(cfg_i.addr, `CMD_OFFSET) && !hit(cfg_i.addr, `STS_OFFSET)
      |=> cfg_rdata_o == 16'h0000)
      else $error("unmapped read nonzero");
   freeze_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !ce_i |=> $stable(cmd_r) && $stable(sts_r) && $stable(cfg_rvalid_o))
      else $error("state moved while clock disabled");

   // sticky status flags
   mdpe_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !mdpe_set && cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET)
      && cfg_i.wdata[`STS_MDPE_BIT] |=> !sts_r[`STS_MDPE_BIT])
      else $error("parity flag not cleared");
   mdpe_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sts_r[`STS_MDPE_BIT] && !(cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET)
      && cfg_i.wdata[`STS_MDPE_BIT]) |=> sts_r[`STS_MDPE_BIT])
      else $error("parity flag dropped");
   sse_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !sse_set && cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET)
      && cfg_i.wdata[`STS_SSE_BIT] |=> !sts_r[`STS_SSE_BIT])
      else $error("system error flag not cleared");
   sse_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && sts_r[`STS_SSE_BIT] && !(cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET)
      && cfg_i.wdata[`STS_SSE_BIT]) |=> sts_r[`STS_SSE_BIT])
      else $error("system error flag dropped");
   sse_only_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ce_i && !serr_en && !sts_r[`STS_SSE_BIT] |=> !sts_r[`STS_SSE_BIT])
      else $error("system error flag set while disabled");

   cov_mdpe_c: cover property (@(posedge clk_sys_i) mdpe_set);
   cov_sse_c: cover property (@(posedge clk_sys_i) sse_set);
   cov_mask_c: cover property (@(posedge clk_sys_i) irq_dis && own_intx_i);
   cov_fwd_c: cover property (@(posedge clk_sys_i) pri_msg_o.nonfatal);
   cov_set_clr_c: cover property (@(posedge clk_sys_i)
      mdpe_set && cfg_i.wr && hit(cfg_i.addr, `STS_OFFSET));
endmodule : bridge_command_error_irq_ctl

/* verilog/cmd_err_regs.svh */
/*
 * register offsets, field positions and reset values for the bridge command/status bank.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef CMD_ERR_REGS_SVH
`define CMD_ERR_REGS_SVH
`define CMD_OFFSET        12'h004
`define STS_OFFSET        12'h006
`define CMD_PALETTE_BIT   5
`define CMD_PERR_BIT      6
`define CMD_STEP_BIT      7
`define CMD_SERR_BIT      8
`define CMD_FAST_BACK_TO_BACK_EN_BIT      9
`define CMD_IRQDIS_BIT    10
`define CMD_RW_MASK       16'h0540
`define CMD_RESET         16'h0000
`define STS_MDPE_BIT      8
`define STS_SSE_BIT       14
`define STS_RESET         16'h0000
`endif

/* verilog/cmd_err_pkg.sv */
/*
 * types shared by the command/error bank.
 * assumes cmd_err_regs.svh supplies the numbers.
 */
package cmd_err_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } cfg_req_type;
   typedef struct packed {
      logic nonfatal;
      logic fatal;
      logic corr;
   } err_msg_type;
endpackage : cmd_err_pkg

/* verilog/msg_fwd.sv */
/*
 * forwards error messages and INTx from secondary to primary, registered.
 * assumes one-cycle message pulses on the same clock.
 */
`timescale 1ns/1ps
module msg_fwd
   import cmd_err_pkg::*;
(
   input  wire logic        clk_sys_i,   // system clock
   input  wire logic        rst_i,       // sync reset
   input  wire logic        ce_i,        // clock enable
   input  wire logic        serr_en_i,   // error report enable
   input  wire err_msg_type sec_msg_i,   // messages from secondary
   input  wire logic [3:0]  sec_intx_i,  // forwarded INTx levels
   output      err_msg_type pri_msg_o,   // messages to primary
   output      logic [3:0]  pri_intx_o   // INTx to primary
);
   err_msg_type msg_r, msg_nxt;
   logic [3:0]  intx_r, intx_nxt;
   always_comb begin
      msg_nxt.corr     = sec_msg_i.corr;
      msg_nxt.nonfatal = sec_msg_i.nonfatal & serr_en_i;
      msg_nxt.fatal    = sec_msg_i.fatal & serr_en_i;
      intx_nxt         = sec_intx_i;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         msg_r  <= '0;
         intx_r <= 4'h0;
      end else if (ce_i) begin
         msg_r  <= msg_nxt;
         intx_r <= intx_nxt;
      end
   end
   assign pri_msg_o  = msg_r;
   assign pri_intx_o = intx_r;
endmodule : msg_fwd

/* dv/rc_model.sv */
/* upstream root complex stand-in: counts error messages arriving on the primary side.
   assumes one-clock message pulses on clk_sys_i. */
`timescale 1ns/1ps
module rc_model
   import cmd_err_pkg::*;
(
   input  wire logic        clk_sys_i, // clock
   input  wire err_msg_type fwd_i,     // forwarded messages
   input  wire err_msg_type own_i,     // bridge's own messages
   output      int          n_corr_o,  // correctable seen
   output      int          n_unc_o    // fatal or nonfatal seen
);
   int corr_cnt = 0;
   int unc_cnt  = 0;
   always @(posedge clk_sys_i) begin
      corr_cnt <= corr_cnt + int'(fwd_i.corr === 1'b1);
      unc_cnt  <= unc_cnt + int'(fwd_i.fatal === 1'b1) + int'(fwd_i.nonfatal === 1'b1)
                  + int'(own_i.fatal === 1'b1) + int'(own_i.nonfatal === 1'b1);
   end
   assign n_corr_o = corr_cnt;
   assign n_unc_o  = unc_cnt;
endmodule : rc_model

/* dv/bridge_command_error_irq_ctl_tb.sv */
/* self-checking bench for the command/error control bank.
   assumes the design files and rc_model are compiled first. */
`timescale 1ns/1ps
`include "cmd_err_regs.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", n, e, a); end end
module bridge_command_error_irq_ctl_tb;
   import cmd_err_pkg::*;
   logic        clk_sys_i = 0, rst_i = 1, pcd = 0, pru = 0, dnf = 0, dft = 0;
   logic        dnfe = 0, dfe = 0, oirq = 0, ce = 1;
   logic [3:0]  sintx = '0, pintx;
   cfg_req_type cfg_r = '0;
   err_msg_type smsg = '0, pmsg, omsg;
   logic [15:0] rdata;
   logic        rvalid, oint, pe, se, idis;
   int          n_errors = 0, checked = 0, n_corr, n_unc;
   logic [15:0] rows [4][2] = '{'{16'hFFFF, 16'h0540}, '{16'h02A0, 16'h0000},
                                '{16'h0140, 16'h0140}, '{16'hF83F, 16'h0000}};
   always #12.5 clk_sys_i = ~clk_sys_i;
   bridge_command_error_irq_ctl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
      .cfg_i(cfg_r), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .poison_cpl_dn_i(pcd),
      .poison_req_up_i(pru), .det_nonfatal_i(dnf), .det_fatal_i(dft),
      .dev_nonfatal_en_i(dnfe), .dev_fatal_en_i(dfe), .sec_msg_i(smsg), .sec_intx_i(sintx),
      .own_intx_i(oirq), .pri_msg_o(pmsg), .own_msg_o(omsg), .pri_intx_o(pintx),
      .own_intx_o(oint), .perr_en_o(pe), .serr_en_o(se), .irq_dis_o(idis));
   rc_model u_rc (.clk_sys_i(clk_sys_i), .fwd_i(pmsg), .own_i(omsg), .n_corr_o(n_corr),
      .n_unc_o(n_unc));
   // one request per call; the release edge is the one that takes it
   task automatic cfg(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys_i) cfg_r <= '{w, ~w, a, d};
      @(posedge clk_sys_i) cfg_r <= '0;
      #1;
   endtask : cfg
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      cfg(1'b0, a, 16'h0000);
      `CHK("rvalid", 1'b1, rvalid)
      `CHK("rdata", e, rdata)
   endtask : rd
   task automatic ev(input logic [6:0] v);
      @(posedge clk_sys_i) {pcd, pru, dnf, dft, smsg} <= v;
      @(posedge clk_sys_i) {pcd, pru, dnf, dft, smsg} <= '0;
      #1;
   endtask : ev
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   initial begin
      #100us;
      n_errors++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(`CMD_OFFSET, 16'h0000);
      rd(`STS_OFFSET, 16'h0000);
      foreach (rows[i]) begin
         cfg(1'b1, `CMD_OFFSET, rows[i][0]);
         rd(`CMD_OFFSET, rows[i][1]);
         `CHK("ctl", {rows[i][1][10], rows[i][1][8], rows[i][1][6]}, {idis, se, pe})
      end
      rd(12'h010, 16'h0000);
      $display("done registers");
      ev(7'h40);
      rd(`STS_OFFSET, 16'h0000);
      cfg(1'b1, `CMD_OFFSET, 16'h0040);
      ev(7'h40);
      rd(`STS_OFFSET, 16'h0100);
      cfg(1'b1, `STS_OFFSET, 16'h0100);
      rd(`STS_OFFSET, 16'h0000);
      ev(7'h20);
      rd(`STS_OFFSET, 16'h0100);
      // poisoned event and write-one clear in one cycle: the set must win
      @(posedge clk_sys_i) cfg_r <= '{1'b1, 1'b0, `STS_OFFSET, 16'h0100};
      pcd <= 1'b1;
      @(posedge clk_sys_i) cfg_r <= '0;
      pcd <= 1'b0;
      #1;
      rd(`STS_OFFSET, 16'h0100);
      cfg(1'b1, `CMD_OFFSET, 16'h0000);
      ev(7'h07);
      `CHK("fwd", 3'b001, pmsg)
      ev(7'h10);
      `CHK("own", 3'b000, omsg)
      @(posedge clk_sys_i) {dnfe, dfe} <= 2'b11;
      ev(7'h18);
      `CHK("own", 3'b110, omsg)
      rd(`STS_OFFSET, 16'h0100);
      @(posedge clk_sys_i) {dnfe, dfe} <= 2'b00;
      cfg(1'b1, `CMD_OFFSET, 16'h0100);
      ev(7'h07);
      `CHK("fwd", 3'b111, pmsg)
      ev(7'h08);
      `CHK("own", 3'b010, omsg)
      rd(`STS_OFFSET, 16'h4100);
      `CHK("rc corr", 2, n_corr)
      `CHK("rc unc", 5, n_unc)
      $display("done errors");
      @(posedge clk_sys_i) {oirq, sintx} <= 5'h1A;
      repeat (2) @(posedge clk_sys_i);
      #1;
      `CHK("own irq", 1'b1, oint)
      cfg(1'b1, `CMD_OFFSET, 16'h0400);
      @(posedge clk_sys_i) #1;
      `CHK("own irq", 1'b0, oint)
      `CHK("fwd irq", 4'hA, pintx)
      $display("done interrupts");
      @(posedge clk_sys_i) rst_i <= 1'b1;
      @(posedge clk_sys_i) rst_i <= 1'b0;
      rd(`CMD_OFFSET, 16'h0000);
      $display("done reset");
      // a write while the clock enable is low must not land
      @(posedge clk_sys_i) ce <= 1'b0;
      cfg(1'b1, `CMD_OFFSET, 16'h0400);
      `CHK("frozen irq", 1'b1, oint)
      `CHK("frozen dis", 1'b0, idis)
      @(posedge clk_sys_i) ce <= 1'b1;
      rd(`CMD_OFFSET, 16'h0000);
      `CHK("own irq", 1'b1, oint)
      $display("done enable");
      complete_run();
   end
endmodule : bridge_command_error_irq_ctl_tb
